// *** bench/osc_far_side.sv ***
// far-side oscillator model: multiplier lock, clock-fail and lock-release pins
`timescale 1ns/100ps
`default_nettype none
module osc_far_side
  import osc_sel_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] sourceSel,
  input  wire logic       failCmd,
  input  wire logic       releaseCmd,
  output var  logic       clockFailPin,
  output var  logic       multLockPin,
  output var  logic       lockReleasePin
);
  logic [3:0] lockCnt_r;
  ////////////////////////////////////////////////////////////
  // loop locks some cycles after a multiplied source is chosen, drops at once otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      lockCnt_r <= 4'h0;
    end else if (sourceSel == SRC_FAST_RC_MULT || sourceSel == SRC_PRIMARY_MULT) begin
      if (lockCnt_r != 4'hf) begin
        lockCnt_r <= lockCnt_r + 4'h1;
      end
    end else begin
      lockCnt_r <= 4'h0;
    end
  end
  assign multLockPin = (lockCnt_r == 4'hf);
  // pads move off the sampling edge, as an unrelated analog source would
  always_ff @(negedge clk) begin
    clockFailPin   <= failCmd;
    lockReleasePin <= releaseCmd;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the oscillator source selector
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import osc_sel_pkg::*;
;
  logic        clk;
  logic        srst;
  reg_req_t    regReq;
  logic [15:0] regRdata;
  logic [2:0]  strap;
  logic        inputKind;
  logic        failCmd;
  logic        releaseCmd;
  logic        clockFailPin;
  logic        multLockPin;
  logic        lockReleasePin;
  osc_ctl_t    oscCtl;
  logic        irq;
  int          err_total;
  int          num_checks;

  osc_source_select osc_source_select_inst (
    .clk                 (clk),
    .srst                (srst),
    .regReq              (regReq),
    .regRdata            (regRdata),
    .initialSourceConfig (strap),
    .secondaryInputKind  (inputKind),
    .clockFailPin        (clockFailPin),
    .multLockPin         (multLockPin),
    .lockReleasePin      (lockReleasePin),
    .oscCtl              (oscCtl),
    .irq                 (irq)
  );

  osc_far_side osc_far_side_inst (
    .clk            (clk),
    .srst           (srst),
    .sourceSel      (oscCtl.sourceSel),
    .failCmd        (failCmd),
    .releaseCmd     (releaseCmd),
    .clockFailPin   (clockFailPin),
    .multLockPin    (multLockPin),
    .lockReleasePin (lockReleasePin)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////
  // compare, count and report at once
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // verdict and end of run, also reached by a wait that runs out
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one-cycle write strobe; returns just after the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq.wr <= 1'b0;
    #1;
  endtask

  // read data only stand in the cycle after the strobe, so sample there
  task automatic rdr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // reads until the masked value matches, at most n times; a miss ends the run
  task automatic poll(input string name, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input int n);
    logic [15:0] d;
    int          i;
    i = 0;
    do begin
      rdr(a, d);
      i++;
    end while ((d & m) !== e && i < n);
    chk(name, e, d & m);
    if ((d & m) !== e) begin
      final_report();
    end
  endtask

  // request a switch and wait for the hardware to finish it
  task automatic sw(input logic [2:0] code);
    wr(OFF_OSC_CTRL, {5'h00, code, 8'h01});
    poll("request", OFF_OSC_CTRL, 16'h0001, 16'h0000, 40);
    poll("current", OFF_OSC_CTRL, 16'h7000, {1'b0, code, 12'h000}, 1);
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    regReq = '0;
    strap = 3'b011;
    inputKind = 1'b1;
    failCmd = 1'b0;
    releaseCmd = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    poll("control reset", OFF_OSC_CTRL, 16'hffff, 16'h0300, 1);
    poll("divider reset", OFF_CLK_DIV, 16'hffff, CLK_DIV_RST, 1);
    poll("tune reset", OFF_RC_TUNE, 16'hffff, RC_TUNE_RST, 1);
    wr(OFF_IRQ_MASK, 16'h0001);
    // every source code, with the switch event raised, masked and cleared
    for (int c = 7; c >= 0; c--) begin
      sw(c[2:0]);
      chk("source pins", {13'h0000, c[2:0]}, {13'h0000, oscCtl.sourceSel});
      poll("switch event", OFF_IRQ_STAT, 16'h0001, 16'h0001, 4);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(OFF_IRQ_MASK, 16'h0000);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(OFF_IRQ_MASK, 16'h0001);
      wr(OFF_IRQ_STAT, 16'h0001);
      chk("irq clear", 16'h0000, {15'h0000, irq});
    end
    // settled flag rises with the loop and drops on a switch away
    sw(SRC_PRIMARY_MULT);
    poll("settled", OFF_OSC_CTRL, 16'h0020, 16'h0020, 300);
    poll("settle event", OFF_IRQ_STAT, 16'h0004, 16'h0004, 1);
    sw(SRC_FAST_RC);
    poll("settled drop", OFF_OSC_CTRL, 16'h0020, 16'h0000, 1);
    // fail flag: set by the pin, a written one has no effect, a zero clears
    failCmd <= 1'b1;
    poll("fail set", OFF_OSC_CTRL, 16'h0008, 16'h0008, 8);
    failCmd <= 1'b0;
    repeat (6) @(posedge clk);
    wr(OFF_OSC_CTRL, 16'h0008);
    poll("fail sticky", OFF_OSC_CTRL, 16'h0008, 16'h0008, 1);
    wr(OFF_OSC_CTRL, 16'h0000);
    poll("fail clear", OFF_OSC_CTRL, 16'h0008, 16'h0000, 1);
    poll("fail event", OFF_IRQ_STAT, 16'h0002, 16'h0002, 1);
    // lock: set only by software, freezes the new source, released by hardware
    wr(OFF_OSC_CTRL, 16'h0080);
    wr(OFF_OSC_CTRL, 16'h0500);
    poll("lock refuse", OFF_OSC_CTRL, 16'h0780, 16'h0080, 1);
    releaseCmd <= 1'b1;
    poll("lock release", OFF_OSC_CTRL, 16'h0080, 16'h0000, 8);
    releaseCmd <= 1'b0;
    wr(OFF_OSC_CTRL, 16'h0500);
    poll("new source", OFF_OSC_CTRL, 16'h0700, 16'h0500, 1);
    // drive bit reaches the pad only for a crystal
    wr(OFF_OSC_CTRL, 16'h0006);
    repeat (5) @(posedge clk);
    #1;
    chk("drive crystal", 16'h0003, {14'h0000, oscCtl.secondaryEnable, oscCtl.secondaryDrive});
    @(posedge clk);
    inputKind <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("drive digital", 16'h0002, {14'h0000, oscCtl.secondaryEnable, oscCtl.secondaryDrive});
    // divider and tuning fields, unused bits read zero except divider bit 15
    wr(OFF_CLK_DIV, 16'hffff);
    wr(OFF_RC_TUNE, 16'hffff);
    poll("divider", OFF_CLK_DIV, 16'hffff, CLK_DIV_MASK, 1);
    poll("tune", OFF_RC_TUNE, 16'hffff, RC_TUNE_MASK, 1);
    chk("divider pins", 16'h1fff,
        {3'h0, oscCtl.dozeEnable, oscCtl.dozeRatio, oscCtl.postscaler, oscCtl.rcTrim});
    wr(4'hf, 16'hffff);
    poll("unmapped", 4'hf, 16'hffff, 16'h0000, 1);
    final_report();
  end
endmodule
`default_nettype wire

// *** hdl/osc_sel_pkg.sv ***
// package: register map, field layout and timing constants of the oscillator selector
package osc_sel_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFF_OSC_CTRL  = 4'h0;
  localparam logic [3:0] OFF_CLK_DIV   = 4'h2;
  localparam logic [3:0] OFF_RC_TUNE   = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT  = 4'h6;
  localparam logic [3:0] OFF_IRQ_MASK  = 4'h8;

  // oscillator_control field positions
  localparam int CUR_LSB   = 12;
  localparam int NEW_LSB   = 8;
  localparam int LOCK_BIT  = 7;
  localparam int SETL_BIT  = 5;
  localparam int FAIL_BIT  = 3;
  localparam int DRV_BIT   = 2;
  localparam int SEN_BIT   = 1;
  localparam int REQ_BIT   = 0;

  // clock_divider_reg fields: doze enable, doze ratio, fast rc postscaler
  localparam int DOZE_EN_BIT = 11;
  localparam int DOZE_LSB    = 12;
  localparam int POST_LSB    = 8;
  localparam logic [15:0] CLK_DIV_RST  = 16'h3100;
  localparam logic [15:0] CLK_DIV_MASK = 16'hff00;

  // rc_tune_reg: six bit signed trim in the low bits
  localparam logic [15:0] RC_TUNE_RST  = 16'h0000;
  localparam logic [15:0] RC_TUNE_MASK = 16'h003f;

  // interrupt status bits
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_FAIL   = 1;
  localparam int IRQ_SETTLE = 2;
  localparam int IRQ_W      = 3;

  // source encodings
  typedef enum logic [2:0] {
    SRC_FAST_RC       = 3'b000,
    SRC_FAST_RC_MULT  = 3'b001,
    SRC_PRIMARY       = 3'b010,
    SRC_PRIMARY_MULT  = 3'b011,
    SRC_SECONDARY     = 3'b100,
    SRC_LOWPOWER_RC   = 3'b101,
    SRC_LP_FAST_RC_DIV= 3'b110,
    SRC_FAST_RC_DIV   = 3'b111
  } src_t;

  // switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_WAIT   = 2'b01,
    SW_COMMIT = 2'b10
  } sw_state_t;

  // timing: switch settle and multiplier lock times
  localparam int CLK_MHZ        = 200;
  localparam int SWITCH_TIME_NS = 100;
  localparam int SWITCH_CYC     = (SWITCH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_TIME_US = 2;
  localparam int SETTLE_CYC     = SETTLE_TIME_US * CLK_MHZ;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // lines to the oscillator pads and analog cells
  typedef struct packed {
    logic [2:0] sourceSel;
    logic       secondaryEnable;
    logic       secondaryDrive;
    logic       dozeEnable;
    logic [2:0] dozeRatio;
    logic [2:0] postscaler;
    logic [5:0] rcTrim;
  } osc_ctl_t;

endpackage

// *** hdl/osc_source_select.sv ***
// oscillator source selection, status and tuning registers
// Function
// - five registers: control, divider, tuning, interrupt status, interrupt mask
// - control requests switch, shows source status
// - current source bits 14:12, reset zero
// - new source bits 10:8, same encoding
// - codes 000, 001, 111: fast RC variants
// - codes 010, 011: primary, primary multiplied
// - codes 100, 101, 110: secondary, lowpower
// - new source reset from configuration setting
// - settled flag cleared on switch, non-multiplier
// - fail set by hardware; lock software-set only
// - current, settled driven by hardware; lock released by hardware
// - drive bit ignored on digital input
// - divider controls doze and postscaler
// - tuning trims fast RC in steps
`timescale 1ns/100ps
`default_nettype none
module osc_source_select
  import osc_sel_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire reg_req_t    regReq,
  output var  logic [15:0] regRdata,
  input  wire logic [2:0]  initialSourceConfig,
  input  wire logic        secondaryInputKind,
  input  wire logic        clockFailPin,
  input  wire logic        multLockPin,
  input  wire logic        lockReleasePin,
  output var  osc_ctl_t    oscCtl,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pad inputs
  logic [2:0] padRaw;
  logic [2:0] padSync;
  logic       failSync;
  logic       multLockSync;
  logic       lockRelSync;

  // one filter per pad; the pads are unrelated to clk, so none may skip the filter
  assign padRaw = {lockReleasePin, multLockPin, clockFailPin};
  for (genvar p = 0; p < 3; p++) begin : g_pad
    sync_filter u_sync (
      .clk  (clk),
      .srst (srst),
      .din  (padRaw[p]),
      .dout (padSync[p])
    );
  end
  assign failSync     = padSync[0];
  assign multLockSync = padSync[1];
  assign lockRelSync  = padSync[2];

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [2:0]       curSrc_r;
  logic [2:0]       newSrc_r;
  logic             switchLock_r;
  logic             settled_r;
  logic             clockFail_r;
  logic             secDrive_r;
  logic             secEnable_r;
  logic             switchReq_r;
  logic [15:0]      clock_divider_reg_r;
  logic [15:0]      rcTune_r;
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic             rstSeen_r;
  sw_state_t        swState_r;
  logic [15:0]      swCnt_r;
  logic [15:0]      setCnt_r;
  logic             failPrev_r;
  logic             setPrev_r;
  logic wrCtrl;
  logic wrDiv;
  logic wrTune;
  logic wrStat;
  logic wrMask;
  logic swDone;
  logic multMode;
  logic failRise;
  logic settleRise;
  logic [IRQ_W-1:0] irqEvent;

  // address decode of the register port
  assign wrCtrl = regReq.wr && (regReq.addr == OFF_OSC_CTRL);
  assign wrDiv  = regReq.wr && (regReq.addr == OFF_CLK_DIV);
  assign wrTune = regReq.wr && (regReq.addr == OFF_RC_TUNE);
  assign wrStat = regReq.wr && (regReq.addr == OFF_IRQ_STAT);
  assign wrMask = regReq.wr && (regReq.addr == OFF_IRQ_MASK);
  // multiplier loop modes are the two multiplied encodings
  assign multMode = (curSrc_r == SRC_FAST_RC_MULT) || (curSrc_r == SRC_PRIMARY_MULT);
  assign swDone   = (swState_r == SW_COMMIT);

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer
  // a switch runs even when the new source equals the current one, so software always sees a commit
  always_ff @(posedge clk) begin
    if (srst) begin
      swState_r <= SW_IDLE;
      swCnt_r   <= 16'h0000;
    end else begin
      case (swState_r)
        SW_IDLE: begin
          if (switchReq_r && rstSeen_r) begin
            swState_r <= SW_WAIT;
            swCnt_r   <= 16'(SWITCH_CYC - 1);
          end
        end
        SW_WAIT: begin
          if (swCnt_r == 16'h0000) begin
            swState_r <= SW_COMMIT;
          end else begin
            swCnt_r <= swCnt_r - 16'h0001;
          end
        end
        SW_COMMIT: begin
          swState_r <= SW_IDLE;
        end
        default: begin
          swState_r <= SW_IDLE;
        end
      endcase
    end
  end

  // current source follows the committed new source
  always_ff @(posedge clk) begin
    if (srst) begin
      curSrc_r <= 3'b000;
    end else if (swDone) begin
      curSrc_r <= newSrc_r;
    end
  end

  // new source: loaded from the configuration strap the cycle after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      rstSeen_r <= 1'b0;
      newSrc_r  <= 3'b000;
    end else if (!rstSeen_r) begin
      rstSeen_r <= 1'b1;
      newSrc_r  <= initialSourceConfig;
    end else if (wrCtrl && !switchLock_r) begin
      newSrc_r  <= regReq.wdata[NEW_LSB +: 3];
    end
  end

  // request bit: software sets, hardware clears on commit; set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      switchReq_r <= 1'b0;
    end else if (wrCtrl && regReq.wdata[REQ_BIT]) begin
      switchReq_r <= 1'b1;
    end else if (swDone) begin
      switchReq_r <= 1'b0;
    end
  end

  // switch lock: software may only set it, hardware releases it
  always_ff @(posedge clk) begin
    if (srst) begin
      switchLock_r <= 1'b0;
    end else if (wrCtrl && regReq.wdata[LOCK_BIT]) begin
      switchLock_r <= 1'b1;
    end else if (lockRelSync) begin
      switchLock_r <= 1'b0;
    end
  end

  // clock fail: hardware sets, software write of zero clears; set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      clockFail_r <= 1'b0;
    end else if (failSync) begin
      clockFail_r <= 1'b1;
    end else if (wrCtrl && !regReq.wdata[FAIL_BIT]) begin
      clockFail_r <= 1'b0;
    end
  end

  // settled flag: counts lock time, forced low on switch or non-multiplier mode
  always_ff @(posedge clk) begin
    if (srst) begin
      settled_r <= 1'b0;
      setCnt_r  <= 16'h0000;
    end else if (swDone || !multMode || !multLockSync) begin
      settled_r <= 1'b0;
      setCnt_r  <= 16'h0000;
    end else if (setCnt_r == 16'(SETTLE_CYC - 1)) begin
      settled_r <= 1'b1;
    end else begin
      setCnt_r  <= setCnt_r + 16'h0001;
    end
  end

  // plain control bits of the control register
  always_ff @(posedge clk) begin
    if (srst) begin
      secDrive_r  <= 1'b0;
      secEnable_r <= 1'b0;
    end else if (wrCtrl) begin
      secDrive_r  <= regReq.wdata[DRV_BIT];
      secEnable_r <= regReq.wdata[SEN_BIT];
    end
  end

  // divider and tuning registers
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_divider_reg_r <= CLK_DIV_RST;
      rcTune_r <= RC_TUNE_RST;
    end else begin
      if (wrDiv) begin
        clock_divider_reg_r <= regReq.wdata & CLK_DIV_MASK;
      end
      if (wrTune) begin
        rcTune_r <= regReq.wdata & RC_TUNE_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      failPrev_r <= 1'b0;
      setPrev_r  <= 1'b0;
    end else begin
      failPrev_r <= clockFail_r;
      setPrev_r  <= settled_r;
    end
  end
  assign failRise   = clockFail_r && !failPrev_r;
  assign settleRise = settled_r && !setPrev_r;
  assign irqEvent   = {settleRise, failRise, swDone};
  generate
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
      always_ff @(posedge clk) begin
        if (srst) begin
          irqStat_r[i] <= 1'b0;
        end else if (irqEvent[i]) begin
          irqStat_r[i] <= 1'b1;
        end else if (wrStat && regReq.wdata[i]) begin
          irqStat_r[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (srst) begin
      irqMask_r <= '0;
    end else if (wrMask) begin
      irqMask_r <= regReq.wdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= 16'h0000;
    end else if (regReq.rd) begin
      case (regReq.addr)
        OFF_OSC_CTRL: regRdata <= {1'b0, curSrc_r, 1'b0, newSrc_r, switchLock_r, 1'b0, settled_r, 1'b0,
                                   clockFail_r, secDrive_r, secEnable_r, switchReq_r};
        OFF_CLK_DIV:  regRdata <= clock_divider_reg_r;
        OFF_RC_TUNE:  regRdata <= rcTune_r;
        OFF_IRQ_STAT: regRdata <= {13'h0000, irqStat_r};
        OFF_IRQ_MASK: regRdata <= {13'h0000, irqMask_r};
        default:      regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the oscillator cells
  always_ff @(posedge clk) begin
    if (srst) begin
      oscCtl <= '0;
    end else begin
      oscCtl.sourceSel       <= curSrc_r;
      oscCtl.secondaryEnable <= secEnable_r;
      oscCtl.secondaryDrive  <= secDrive_r && secondaryInputKind;
      oscCtl.dozeEnable      <= clock_divider_reg_r[DOZE_EN_BIT];
      oscCtl.dozeRatio       <= clock_divider_reg_r[DOZE_LSB +: 3];
      oscCtl.postscaler      <= clock_divider_reg_r[POST_LSB +: 3];
      oscCtl.rcTrim          <= rcTune_r[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions; logic operators take the commit strobe as a plain expression, not the sequence
  sequence req_taken_s;
    swState_r == SW_IDLE && switchReq_r && rstSeen_r;
  endsequence
  sequence commit_s;
    swState_r == SW_COMMIT;
  endsequence
  switch_commit_a: assert property (@(posedge clk) disable iff (srst)
    req_taken_s |=> (swState_r == SW_WAIT) [*1] ##[0:30] commit_s)
    else $error("switch did not commit in time");
  req_clear_a: assert property (@(posedge clk) disable iff (srst)
    swDone && !(wrCtrl && regReq.wdata[REQ_BIT]) |=> !switchReq_r)
    else $error("request bit not cleared after switch");
  cur_update_a: assert property (@(posedge clk) disable iff (srst)
    commit_s |=> curSrc_r == $past(newSrc_r))
    else $error("current source not updated on commit");
  cur_stable_a: assert property (@(posedge clk) disable iff (srst)
    !swDone |=> $stable(curSrc_r))
    else $error("current source changed without switch");
  settle_low_a: assert property (@(posedge clk) disable iff (srst)
    (swDone || !multMode) |=> !settled_r)
    else $error("settled flag not forced low");
  fail_sticky_a: assert property (@(posedge clk) disable iff (srst)
    clockFail_r && !(wrCtrl && !regReq.wdata[FAIL_BIT]) |=> clockFail_r)
    else $error("clock fail flag dropped without software clear");
  lock_hold_a: assert property (@(posedge clk) disable iff (srst)
    switchLock_r && !lockRelSync |=> switchLock_r)
    else $error("switch lock dropped without hardware release");
  new_locked_a: assert property (@(posedge clk) disable iff (srst)
    rstSeen_r && switchLock_r |=> $stable(newSrc_r))
    else $error("new source changed while locked");
  drive_ignore_a: assert property (@(posedge clk) disable iff (srst)
    !secondaryInputKind && !$past(secondaryInputKind) |=> !oscCtl.secondaryDrive)
    else $error("drive bit active on digital input");
  div_write_a: assert property (@(posedge clk) disable iff (srst)
    wrDiv |=> clock_divider_reg_r == ($past(regReq.wdata) & CLK_DIV_MASK))
    else $error("divider write lost");

endmodule
`default_nettype wire

// *** hdl/sync_filter.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sync_filter
  import osc_sel_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output var  logic dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // the first stage is read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // output moves only when second and third agree, so one-cycle glitches are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      dout <= 1'b0;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end

endmodule
`default_nettype wire
